// File: src/urx_regs.svh
// Timing, field and reset constants of the UART receive path
`ifndef URX_REGS_SVH
`define URX_REGS_SVH

// ----------------------------------------------------------------
// Oversampling timing (16 ticks per bit, 3-sample vote)
// ----------------------------------------------------------------
`define URX_TICK_ZERO 4'h0
`define URX_TICK_VOTE_A 4'h7
`define URX_TICK_VOTE_B 4'h8
`define URX_TICK_VOTE_C 4'h9
`define URX_TICK_LAST 4'hF

// ----------------------------------------------------------------
// Frame lengths (index of the last shifted bit) and first bit index
// ----------------------------------------------------------------
`define URX_LAST_BIT_8 4'h7
`define URX_LAST_BIT_9 4'h8
`define URX_BIT_ZERO 4'h0

// ----------------------------------------------------------------
// Stored word layout: {noise, parity error, framing error, data}
// ----------------------------------------------------------------
`define URX_WORD_W 12
`define URX_DATA_W 9
`define URX_F_NINTH 8
`define URX_F_FE 9
`define URX_F_PE 10
`define URX_F_NF 11

// ----------------------------------------------------------------
// Reset values and FIFO depth
// ----------------------------------------------------------------
`define URX_DIV_RESET 16'h0000
`define URX_MODE_RESET 3'h0
`define URX_FIFO_DEPTH 4

`endif

// File: src/urx_pkg.sv
// Types shared by the UART receive path
`include "urx_regs.svh"

package urx_pkg;

  // Receiver frame states, one-hot
  typedef enum logic [5:0] {
    URX_IDLE = 6'h01,
    URX_START = 6'h02,
    URX_DATA = 6'h04,
    URX_STOP = 6'h08,
    URX_WAIT_HIGH = 6'h10,
    URX_SPARE = 6'h20
  } urx_state_t;

  // Parity type codes
  typedef enum logic [1:0] {
    URX_PAR_EVEN = 2'h0,
    URX_PAR_ODD = 2'h1,
    URX_PAR_MARK = 2'h2,
    URX_PAR_SPACE = 2'h3
  } urx_parity_t;

  // Complete register state of the receiver
  typedef struct packed {
    urx_state_t st;
    logic [15:0] pre_cnt;
    logic [2:0] mode_cnt;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] samp;
    logic noisy;
    logic [`URX_DATA_W-1:0] shreg;
    logic stop_bad;
    logic stop_two;
    logic pend_valid;
    logic [`URX_WORD_W-1:0] pend_word;
    logic overrun;
    logic noise;
    logic armed;
    logic idle;
    logic irq;
  } urx_state_reg_t;

endpackage

// File: src/urx_fifo.sv
// Parameterised flop FIFO with valid/ready on both sides
module urx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1),
  parameter int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] cnt;
  } urx_fifo_state_t;

  urx_fifo_state_t s;
  urx_fifo_state_t next_s;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (s.cnt != CW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rd_ptr];
  assign count = s.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;

  // Pointer and count update, explicit wrap for any depth
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : s.wr_ptr + PW'(1);
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : s.rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + CW'(1);
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // A full FIFO never takes a word
  property p_fifo_full_holds;
    @(posedge clk) disable iff (!rst_n)
    (s.cnt == CW'(DEPTH)) && !pop |=> (s.cnt == CW'(DEPTH));
  endproperty
  a_fifo_full_holds: assert property (p_fifo_full_holds) else $error("full fifo count moved");

endmodule // urx_fifo

// File: src/urx_receiver.sv
// UART receive path: oversampled receiver, word FIFO, flags and interrupt
`include "urx_regs.svh"

module urx_receiver #(
  parameter int FIFO_DEPTH = `URX_FIFO_DEPTH,
  parameter int CW = $clog2(FIFO_DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic serial_rx_pin,
  input wire logic receiver_enable,
  input wire logic nine_bit_select,
  input wire logic parity_enable,
  input wire urx_pkg::urx_parity_t parity_type_field,
  input wire logic stop_bits_select,
  input wire logic [7:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  input wire logic [2:0] baud_mode_field,
  input wire logic rx_irq_enable,
  input wire logic [1:0] rx_trigger_level,
  input wire logic status_access,
  input wire logic data_read,
  output logic [7:0] rx_data,
  output logic rx_ninth_bit,
  output logic rx_data_available,
  output logic [CW-1:0] rx_fill_count,
  output logic overrun_flag,
  output logic noise_flag,
  output logic framing_error_flag,
  output logic parity_error_flag,
  output logic rx_idle_flag,
  output logic rx_irq
);
  import urx_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  // Two-flop release of the asynchronous reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  urx_state_reg_t s;
  urx_state_reg_t next_s;
  logic [15:0] divisor;
  logic tick;
  logic maj;
  logic noise_now;
  logic [3:0] last_bit;
  logic [`URX_WORD_W-1:0] done_word;
  logic done;
  logic done_fe;
  logic par_err;
  logic data_xor;
  logic top_bit;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`URX_WORD_W-1:0] fifo_out_data;
  logic [CW-1:0] fill;
  logic push;
  logic pop;
  logic [CW:0] fill_after;
  logic [CW:0] trig_words;
  logic seq_clear;

  // ----------------------------------------------------------------
  // Bit timing and sample vote
  // ----------------------------------------------------------------

  // 16x tick every (divisor+1)*(mode+1) clocks
  assign divisor = {baud_divisor_high, baud_divisor_low};
  assign tick = (s.st != URX_IDLE) && (s.pre_cnt == divisor) &&
                (s.mode_cnt == baud_mode_field);

  // Majority of samples at ticks 7, 8 and the live one at 9
  assign maj = (s.samp[0] & s.samp[1]) | (s.samp[0] & serial_rx_pin) |
               (s.samp[1] & serial_rx_pin);
  assign noise_now = !((s.samp[0] == s.samp[1]) && (s.samp[1] == serial_rx_pin));

  // Word length select
  assign last_bit = nine_bit_select ? `URX_LAST_BIT_9 : `URX_LAST_BIT_8;

  // ----------------------------------------------------------------
  // Frame end, parity and stored word
  // ----------------------------------------------------------------

  // Final stop sample completes the frame
  assign done = (s.st == URX_STOP) && tick && (s.tick_cnt == `URX_TICK_VOTE_C) &&
                !s.stop_two;
  assign done_fe = s.stop_bad || !maj;

  // Parity bit is the last bit of the word
  assign data_xor = ^s.shreg;
  assign top_bit = nine_bit_select ? s.shreg[`URX_F_NINTH] : s.shreg[`URX_LAST_BIT_8];

  // Parity check per type code
  always_comb begin
    case (parity_type_field)
      URX_PAR_EVEN: par_err = data_xor;
      URX_PAR_ODD: par_err = !data_xor;
      URX_PAR_MARK: par_err = !top_bit;
      URX_PAR_SPACE: par_err = top_bit;
      default: par_err = 1'b0;
    endcase
  end

  // Word as stored: flags travel with the data
  assign done_word = {s.noisy || noise_now, parity_enable && par_err, done_fe,
                      s.shreg};

  // ----------------------------------------------------------------
  // FIFO handshake and trigger level
  // ----------------------------------------------------------------
  assign push = s.pend_valid && fifo_in_ready;
  assign pop = data_read && fifo_out_valid;
  assign seq_clear = data_read && s.armed;
  assign fill_after = {1'b0, fill} + (CW + 1)'(push) - (CW + 1)'(pop);
  assign trig_words = (CW + 1)'(rx_trigger_level) + (CW + 1)'(1);

  // Word FIFO; the held word waits in pend_word while it is full
  urx_fifo #(
    .WIDTH(`URX_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(rst_sync),
    .in_valid(s.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(s.pend_word),
    .out_valid(fifo_out_valid),
    .out_ready(data_read),
    .out_data(fifo_out_data),
    .count(fill)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;

    // Prescaler for the 16x tick, restarted while idle
    if (s.st == URX_IDLE) begin
      next_s.pre_cnt = `URX_DIV_RESET;
      next_s.mode_cnt = `URX_MODE_RESET;
    end else if (s.pre_cnt == divisor) begin
      next_s.pre_cnt = `URX_DIV_RESET;
      next_s.mode_cnt = tick ? `URX_MODE_RESET : s.mode_cnt + 3'h1;
    end else begin
      next_s.pre_cnt = s.pre_cnt + 16'h0001;
    end

    // Tick position and early samples within the bit
    if (tick) begin
      next_s.tick_cnt = s.tick_cnt + 4'h1;
      if (s.tick_cnt == `URX_TICK_VOTE_A) begin
        next_s.samp[0] = serial_rx_pin;
      end
      if (s.tick_cnt == `URX_TICK_VOTE_B) begin
        next_s.samp[1] = serial_rx_pin;
      end
    end

    // Frame sequencer
    case (s.st)
      URX_IDLE: begin
        next_s.tick_cnt = `URX_TICK_ZERO;
        if (receiver_enable && !serial_rx_pin) begin
          next_s.st = URX_START;
          next_s.idle = 1'b0;
          next_s.noisy = 1'b0;
          next_s.stop_bad = 1'b0;
          next_s.bit_cnt = `URX_BIT_ZERO;
          next_s.shreg = '0;
        end
      end
      URX_START: begin
        if (tick && (s.tick_cnt == `URX_TICK_VOTE_C)) begin
          next_s.noisy = noise_now;
          if (maj) begin
            next_s.st = URX_IDLE; // False start
            next_s.idle = 1'b1;
          end
        end else if (tick && (s.tick_cnt == `URX_TICK_LAST)) begin
          next_s.st = URX_DATA;
        end
      end
      URX_DATA: begin
        if (tick && (s.tick_cnt == `URX_TICK_VOTE_C)) begin
          next_s.shreg[s.bit_cnt] = maj;
          next_s.noisy = s.noisy || noise_now;
        end else if (tick && (s.tick_cnt == `URX_TICK_LAST)) begin
          if (s.bit_cnt == last_bit) begin
            next_s.st = URX_STOP;
            next_s.stop_two = stop_bits_select;
          end else begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
        end
      end
      URX_STOP: begin
        if (done) begin
          next_s.idle = 1'b1;
          next_s.st = done_fe ? URX_WAIT_HIGH : URX_IDLE;
        end else if (tick && (s.tick_cnt == `URX_TICK_VOTE_C)) begin
          next_s.stop_bad = s.stop_bad || !maj;
          next_s.noisy = s.noisy || noise_now;
        end else if (tick && (s.tick_cnt == `URX_TICK_LAST)) begin
          next_s.stop_two = 1'b0;
        end
      end
      URX_WAIT_HIGH: begin
        if (serial_rx_pin) begin
          next_s.st = URX_IDLE;
        end
      end
      default: begin
        next_s.st = URX_IDLE;
      end
    endcase

    // Disabling drops any frame in progress
    if (!receiver_enable) begin
      next_s.st = URX_IDLE;
      next_s.idle = 1'b1;
    end

    // Held word drains into the FIFO when room appears
    if (push) begin
      next_s.pend_valid = 1'b0;
    end

    // Completed word lands in the held slot
    if (done) begin
      next_s.pend_valid = 1'b1;
      next_s.pend_word = done_word;
      if (s.pend_valid && !fifo_in_ready) begin
        next_s.overrun = 1'b1;
        next_s.irq = rx_irq_enable;
      end
    end

    // Two-step clear: status access arms, data read fires
    if (status_access) begin
      next_s.armed = 1'b1;
    end else if (data_read) begin
      next_s.armed = 1'b0;
    end
    if (seq_clear) begin
      next_s.overrun = 1'b0;
      next_s.noise = 1'b0;
    end

    // Sets after clears so an event in the clear cycle survives
    if (done && s.pend_valid && !fifo_in_ready) begin
      next_s.overrun = 1'b1;
    end
    if (push && s.pend_word[`URX_F_NF]) begin
      next_s.noise = 1'b1;
    end

    // Trigger interrupt when a transfer reaches the level
    if (push && rx_irq_enable && (fill_after >= trig_words)) begin
      next_s.irq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= '{st: URX_IDLE, idle: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Head word and its stored flags
  assign rx_data = fifo_out_data[7:0];
  assign rx_ninth_bit = fifo_out_data[`URX_F_NINTH];
  assign framing_error_flag = fifo_out_valid && fifo_out_data[`URX_F_FE];
  assign parity_error_flag = fifo_out_valid && fifo_out_data[`URX_F_PE];
  assign rx_data_available = fifo_out_valid;
  assign rx_fill_count = fill;
  assign overrun_flag = s.overrun;
  assign noise_flag = s.noise;
  assign rx_idle_flag = s.idle;
  assign rx_irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_frame_low_stop;
    done && !maj;
  endsequence

  sequence s_overrun_hit;
    done && s.pend_valid && !fifo_in_ready;
  endsequence

  property p_available_count;
    @(posedge mclk) disable iff (!rst_sync)
    rx_data_available == (rx_fill_count != '0);
  endproperty
  a_available_count: assert property (p_available_count) else $error("available vs count");

  property p_overrun_set;
    @(posedge mclk) disable iff (!rst_sync)
    s_overrun_hit |=> overrun_flag && s.pend_valid &&
      (rx_fill_count == CW'(FIFO_DEPTH) - CW'($past(pop)));
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not handled");

  property p_overrun_clear;
    @(posedge mclk) disable iff (!rst_sync)
    $fell(overrun_flag) |-> $past(data_read) && $past(s.armed);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun cleared early");

  property p_frame_error;
    @(posedge mclk) disable iff (!rst_sync)
    s_frame_low_stop |=> s.pend_word[`URX_F_FE] && rx_idle_flag && (s.st != URX_START);
  endproperty
  a_frame_error: assert property (p_frame_error) else $error("low stop not flagged");

  property p_wait_high;
    @(posedge mclk) disable iff (!rst_sync)
    (s.st == URX_WAIT_HIGH) && !serial_rx_pin && receiver_enable |=> (s.st == URX_WAIT_HIGH);
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("left wait on low line");

  property p_idle_in_frame;
    @(posedge mclk) disable iff (!rst_sync)
    (s.st == URX_DATA) || (s.st == URX_START) |-> !rx_idle_flag;
  endproperty
  a_idle_in_frame: assert property (p_idle_in_frame) else $error("idle high in frame");

  property p_trigger_irq;
    @(posedge mclk) disable iff (!rst_sync)
    push && rx_irq_enable && (fill_after >= trig_words) |=> rx_irq;
  endproperty
  a_trigger_irq: assert property (p_trigger_irq) else $error("trigger irq missing");

  property p_noise_flag;
    @(posedge mclk) disable iff (!rst_sync)
    push && s.pend_word[`URX_F_NF] |=> noise_flag ##1 noise_flag || $past(seq_clear);
  endproperty
  a_noise_flag: assert property (p_noise_flag) else $error("noise flag missing");

  property p_disable_idle;
    @(posedge mclk) disable iff (!rst_sync)
    !receiver_enable |=> (s.st == URX_IDLE) && rx_idle_flag;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("disable ignored");

endmodule // urx_receiver

// File: sim/urx_serial_src.sv
// Behavioural remote serial transmitter driving the receive line
module urx_serial_src #(
  parameter int BT = 32
) (
  input wire logic mclk,
  output logic serial_rx_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Line idles high between frames
  // ----------------------------------------------------------------
  initial begin
    serial_rx_pin = 1'b1;
  end

  // One frame: start, nb bits LSB first, ns stops; optional glitch
  task automatic send(input logic [8:0] w, input int nb, input int ns, input logic bad,
                      input int nz);
    for (int b = 0; b < nb + ns + 1; b++) begin
      logic v;
      // Bad flag pulls only the last stop position low
      v = (b == 0) ? 1'b0 : (b <= nb) ? w[b-1] : !(bad && b == nb + ns);
      for (int c = 0; c < BT; c++) begin
        @(negedge mclk);
        // Two-cycle glitch hits only the middle of the three samples
        serial_rx_pin <= (b == nz + 1 && (c == BT / 2 + 2 || c == BT / 2 + 3)) ? !v : v;
      end
    end
    @(negedge mclk);
    serial_rx_pin <= 1'b1;
  endtask

  // Break: line held low for nbits bit times, then two high stops
  task automatic brk(input int nbits);
    repeat (nbits * BT) @(negedge mclk) serial_rx_pin <= 1'b0;
    repeat (2 * BT) @(negedge mclk) serial_rx_pin <= 1'b1;
  endtask
endmodule // urx_serial_src

// File: sim/testbench.sv
// Self-checking bench of the UART receive path
module testbench;
  import urx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk, rstn, serial_rx_pin, receiver_enable, nine_bit_select, parity_enable;
  urx_parity_t parity_type_field;
  logic stop_bits_select, rx_irq_enable, status_access, data_read;
  logic [7:0] baud_divisor_high, baud_divisor_low, rx_data;
  logic [2:0] baud_mode_field, rx_fill_count;
  logic [1:0] rx_trigger_level;
  logic rx_ninth_bit, rx_data_available, overrun_flag, noise_flag;
  logic framing_error_flag, parity_error_flag, rx_idle_flag, rx_irq;
  int fails, total_checks, irq_cnt, cyc, i0;
  logic [7:0] d;
  logic p;

  // ----------------------------------------------------------------
  // Design, far-side transmitter, clock
  // ----------------------------------------------------------------
  urx_receiver DUT (.mclk(mclk), .rstn(rstn), .serial_rx_pin(serial_rx_pin),
    .receiver_enable(receiver_enable), .nine_bit_select(nine_bit_select),
    .parity_enable(parity_enable), .parity_type_field(parity_type_field),
    .stop_bits_select(stop_bits_select), .baud_divisor_high(baud_divisor_high),
    .baud_divisor_low(baud_divisor_low), .baud_mode_field(baud_mode_field),
    .rx_irq_enable(rx_irq_enable), .rx_trigger_level(rx_trigger_level),
    .status_access(status_access), .data_read(data_read), .rx_data(rx_data),
    .rx_ninth_bit(rx_ninth_bit), .rx_data_available(rx_data_available),
    .rx_fill_count(rx_fill_count), .overrun_flag(overrun_flag), .noise_flag(noise_flag),
    .framing_error_flag(framing_error_flag), .parity_error_flag(parity_error_flag),
    .rx_idle_flag(rx_idle_flag), .rx_irq(rx_irq));

  // Tick period (1+1)*(0+1) = 2 clocks, so 32 clocks a bit
  urx_serial_src #(.BT(32)) src (.mclk(mclk), .serial_rx_pin(serial_rx_pin));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Interrupt pulse counter and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (rx_irq === 1'b1) irq_cnt++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Frame and settle until the word sits in the FIFO
  task automatic fr(input logic [8:0] w, input int nb, input int ns, input logic bad,
                    input int nz);
    src.send(w, nb, ns, bad, nz);
    repeat (4) @(negedge mclk);
  endtask

  // Check head word, then optional status access and a data read
  task automatic rd(input logic [8:0] w, input logic fe, input logic pe, input logic st);
    chk("rx_data", 16'(w[7:0]), 16'(rx_data));
    chk("rx_ninth_bit", 16'(w[8]), 16'(rx_ninth_bit));
    chk("framing_error_flag", 16'(fe), 16'(framing_error_flag));
    chk("parity_error_flag", 16'(pe), 16'(parity_error_flag));
    @(negedge mclk);
    status_access = st;
    @(negedge mclk);
    status_access = 1'b0;
    data_read = 1'b1;
    @(negedge mclk);
    data_read = 1'b0;
    @(negedge mclk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    receiver_enable = 1'b0;
    nine_bit_select = 1'b0;
    parity_enable = 1'b0;
    parity_type_field = URX_PAR_EVEN;
    stop_bits_select = 1'b0;
    baud_divisor_high = 8'h00;
    baud_divisor_low = 8'h01;
    baud_mode_field = 3'h0;
    rx_irq_enable = 1'b1;
    rx_trigger_level = 2'h0;
    status_access = 1'b0;
    data_read = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    // Reset values
    chk("avail", 16'h0, 16'(rx_data_available));
    chk("idle", 16'h1, 16'(rx_idle_flag));
    chk("flags", 16'h0, 16'({overrun_flag, noise_flag, framing_error_flag}));
    // Disabled receiver ignores a frame
    fr(9'h03C, 8, 1, 1'b0, 99);
    chk("fill", 16'h0, 16'(rx_fill_count));
    receiver_enable = 1'b1;
    // Plain frame, idle low mid-frame
    fork
      fr(9'h0A5, 8, 1, 1'b0, 99);
      begin
        repeat (100) @(negedge mclk);
        chk("idle", 16'h0, 16'(rx_idle_flag));
      end
    join
    chk("fill", 16'h1, 16'(rx_fill_count));
    chk("irq", 16'h1, 16'(irq_cnt));
    chk("idle", 16'h1, 16'(rx_idle_flag));
    rd(9'h0A5, 1'b0, 1'b0, 1'b1);
    chk("avail", 16'h0, 16'(rx_data_available));
    // Nine-bit word, then every parity type good and bad
    nine_bit_select = 1'b1;
    fr(9'h1C3, 9, 1, 1'b0, 99);
    rd(9'h1C3, 1'b0, 1'b0, 1'b1);
    parity_enable = 1'b1;
    for (int t = 0; t < 4; t++) begin
      parity_type_field = urx_parity_t'(t[1:0]);
      for (int b = 0; b < 2; b++) begin
        d = 8'h5A ^ 8'(t);
        p = (t == 0) ? ^d : (t == 1) ? ~^d : (t == 2);
        fr({p ^ b[0], d}, 9, 1, 1'b0, 99);
        rd({p ^ b[0], d}, 1'b0, b[0], 1'b1);
      end
    end
    parity_enable = 1'b0;
    nine_bit_select = 1'b0;
    // Two stops at the same rate through the mode divider; low stop is a framing error
    baud_divisor_low = 8'h00;
    baud_mode_field = 3'h1;
    stop_bits_select = 1'b1;
    fr(9'h081, 8, 2, 1'b0, 99);
    fr(9'h07E, 8, 2, 1'b1, 99);
    rd(9'h081, 1'b0, 1'b0, 1'b1);
    rd(9'h07E, 1'b1, 1'b0, 1'b1);
    // Ninth bit low lands on the first stop position
    fr(9'h03C, 9, 1, 1'b0, 99);
    rd(9'h03C, 1'b1, 1'b0, 1'b1);
    stop_bits_select = 1'b0;
    baud_divisor_low = 8'h01;
    baud_mode_field = 3'h0;
    // Long break gives one zero word only
    src.brk(20);
    repeat (4) @(negedge mclk);
    chk("fill", 16'h1, 16'(rx_fill_count));
    chk("idle", 16'h1, 16'(rx_idle_flag));
    rd(9'h000, 1'b1, 1'b0, 1'b1);
    // Noise in data bit 2: word kept, one irq per word
    i0 = irq_cnt;
    fr(9'h096, 8, 1, 1'b0, 2);
    fr(9'h011, 8, 1, 1'b0, 99);
    chk("noise", 16'h1, 16'(noise_flag));
    chk("irq", 16'h2, 16'(irq_cnt - i0));
    rd(9'h096, 1'b0, 1'b0, 1'b0);
    chk("noise", 16'h1, 16'(noise_flag));
    rd(9'h011, 1'b0, 1'b0, 1'b1);
    chk("noise", 16'h0, 16'(noise_flag));
    // Fill to four at trigger four, held word, then overrun
    rx_trigger_level = 2'h3;
    i0 = irq_cnt;
    for (int k = 1; k < 5; k++) fr(9'(k * 8'h11), 8, 1, 1'b0, 99);
    chk("fill", 16'h4, 16'(rx_fill_count));
    chk("irq", 16'h1, 16'(irq_cnt - i0));
    fr(9'h055, 8, 1, 1'b0, 99);
    chk("overrun", 16'h0, 16'(overrun_flag));
    fr(9'h0AA, 8, 1, 1'b0, 99);
    chk("overrun", 16'h1, 16'(overrun_flag));
    chk("irq", 16'h2, 16'(irq_cnt - i0));
    chk("fill", 16'h4, 16'(rx_fill_count));
    rd(9'h011, 1'b0, 1'b0, 1'b1);
    chk("overrun", 16'h0, 16'(overrun_flag));
    for (int k = 2; k < 5; k++) rd(9'(k * 8'h11), 1'b0, 1'b0, 1'b1);
    rd(9'h0AA, 1'b0, 1'b0, 1'b1);
    chk("avail", 16'h0, 16'(rx_data_available));
    // Suspended receiver drops a frame, then a masked word raises no irq
    receiver_enable = 1'b0;
    fr(9'h066, 8, 1, 1'b0, 99);
    chk("fill", 16'h0, 16'(rx_fill_count));
    receiver_enable = 1'b1;
    rx_irq_enable = 1'b0;
    rx_trigger_level = 2'h0;
    i0 = irq_cnt;
    fr(9'h066, 8, 1, 1'b0, 99);
    chk("irq", 16'h0, 16'(irq_cnt - i0));
    rd(9'h066, 1'b0, 1'b0, 1'b1);
    end_sim();
  end
endmodule // testbench
